// ===== design/vsr_pkg.sv
// Constants, types and timing for the bus slave and its two-half data router.
// Assumes one 20 MHz clock and a synchronous active-high reset in every user.
`default_nettype none
package vsr_pkg;
	localparam int CLK_NS = 50;
	localparam int LINK_HOLD_NS = 2000;
	localparam int LINK_HOLD_CYC = (LINK_HOLD_NS / CLK_NS) > 0 ? (LINK_HOLD_NS / CLK_NS) : 1;
	localparam logic [5:0] AM_EXT_SBLK = 6'h0F;
	localparam logic [5:0] AM_EXT_SPRG = 6'h0E;
	localparam logic [5:0] AM_EXT_SDAT = 6'h0D;
	localparam logic [5:0] AM_EXT_NBLK = 6'h0B;
	localparam logic [5:0] AM_EXT_NPRG = 6'h0A;
	localparam logic [5:0] AM_EXT_NDAT = 6'h09;
	localparam logic [5:0] AM_STD_SBLK = 6'h3F;
	localparam logic [5:0] AM_STD_SPRG = 6'h3E;
	localparam logic [5:0] AM_STD_SDAT = 6'h3D;
	localparam logic [5:0] AM_STD_NBLK = 6'h3B;
	localparam logic [5:0] AM_STD_NPRG = 6'h3A;
	localparam logic [5:0] AM_STD_NDAT = 6'h39;
	localparam logic [27:0] LO_BASE = 28'h002_0000;
	localparam logic [27:0] LO_LAST = 28'h005_FFFF;
	localparam int ROUTE_BIT = 19;
	typedef enum logic [2:0] {ST_IDLE, ST_SEL, ST_WAIT, ST_XFER, ST_ACK, ST_END} vsr_state_e;
endpackage
`default_nettype wire

// ===== design/vsr_link_if.sv
// Inter-half link carrying address, routing flag and data both ways.
// Assumes both ends share the core clock.
`timescale 1ns/1ns
`default_nettype none
interface vsr_link_if;
	logic req;
	logic wr;
	logic lo;
	logic we_hi;
	logic [19:0] addr;
	logic [31:0] to_lo;
	logic [31:0] to_up;
	modport upper (output req, wr, lo, we_hi, addr, to_lo, input to_up);
	modport lower (input req, wr, lo, we_hi, addr, to_lo, output to_up);
endinterface
`default_nettype wire

// ===== design/vsr_am_decode.sv
// Modifier decode and board-select compare.
// Assumes address and modifier lines are stable while the address strobe is low.
`timescale 1ns/1ns
`default_nettype none
module vsr_am_decode
	import vsr_pkg::*;
(
	input wire logic [5:0] am_in,
	input wire logic [31:28] addr_ext_in,
	input wire logic [23:20] addr_std_in,
	input wire logic [3:0] board_sw_in,
	output logic am_ok_out,
	output logic ext_out,
	output logic match_out
);
	always_comb begin
		am_ok_out = 1'b1;
		ext_out = 1'b0;
		case (am_in)
			AM_EXT_SBLK, AM_EXT_SPRG, AM_EXT_SDAT,
			AM_EXT_NBLK, AM_EXT_NPRG, AM_EXT_NDAT: ext_out = 1'b1;
			AM_STD_SBLK, AM_STD_SPRG, AM_STD_SDAT,
			AM_STD_NBLK, AM_STD_NPRG, AM_STD_NDAT: ext_out = 1'b0;
			default: am_ok_out = 1'b0;
		endcase
	end
	assign match_out = (ext_out ? addr_ext_in : addr_std_in) == board_sw_in;
endmodule
`default_nettype wire

// ===== design/vsr_lower_route.sv
// Lower half: route flag handling, data routing and lower memory.
// Assumes link requests last one cycle and the local process honours its grant.
`timescale 1ns/1ns
`default_nettype none
module vsr_lower_route
	import vsr_pkg::*;
#(
	parameter int LO_AW = 8
) (
	input wire logic clk_in,
	input wire logic rst_in,
	vsr_link_if.lower lk,
	input wire logic [15:0] bus_upper_lane_in,
	output logic [15:0] bus_upper_lane_out,
	input wire logic lp_en_in,
	input wire logic lp_we_in,
	input wire logic [19:0] lp_addr_in,
	input wire logic [31:0] lp_wdata_in,
	output logic lp_gnt_out,
	output logic [31:0] lp_rdata_out
);
	typedef struct packed {
		logic [31:0] lp_rd;
	} vsr_lo_s;
	vsr_lo_s r_q;
	vsr_lo_s r_d;
	logic [31:0] mem [2**LO_AW];
	logic bus_route_flag;
	logic [19:0] link_received_mem_addr;
	logic [19:0] cleaned_mem_addr;
	logic [31:0] link_received_data;
	logic [31:0] local_mem_write_data;
	logic [31:0] local_mem_read_data;
	logic link_sel;
	logic [LO_AW-1:0] idx;

	function automatic logic [LO_AW-1:0] lo_idx(input logic [19:0] a);
		logic [19:0] off;
		off = a - LO_BASE[19:0];
		return off[LO_AW+1:2];
	endfunction

	assign link_received_mem_addr = lk.addr;
	assign link_received_data = lk.to_lo;
	assign bus_route_flag = link_received_mem_addr[ROUTE_BIT];
	assign cleaned_mem_addr = {1'b0, link_received_mem_addr[18:0]};
	assign link_sel = lk.req && lk.lo;
	assign lp_gnt_out = !link_sel;
	assign idx = link_sel ? lo_idx(cleaned_mem_addr) : lo_idx(lp_addr_in);
	assign local_mem_read_data = mem[idx];

	always_comb begin
		if (!bus_route_flag) begin
			local_mem_write_data = link_received_data;
			lk.to_up = local_mem_read_data;
			bus_upper_lane_out = local_mem_read_data[31:16];
		end else begin
			local_mem_write_data = {bus_upper_lane_in, link_received_data[15:0]};
			lk.to_up = {bus_upper_lane_in, local_mem_read_data[15:0]};
			bus_upper_lane_out = link_received_data[31:16];
		end
	end

	always_ff @(posedge clk_in) begin
		if (link_sel && lk.wr) begin
			if (lk.we_hi) begin
				mem[idx][31:16] <= local_mem_write_data[31:16];
			end
			mem[idx][15:0] <= local_mem_write_data[15:0];
		end else if (lp_en_in && lp_we_in) begin
			mem[idx] <= lp_wdata_in;
		end
	end

	always_comb begin
		r_d = r_q;
		if (lp_en_in && !link_sel) begin
			r_d.lp_rd = local_mem_read_data;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end
	assign lp_rdata_out = r_q.lp_rd;

	property p_lo_write_route;
		@(posedge clk_in) disable iff (rst_in)
		link_sel && lk.wr && lk.we_hi && bus_route_flag |=>
		mem[$past(idx)][31:16] == $past(bus_upper_lane_in);
	endproperty
	a_lo_write_route: assert property (p_lo_write_route) else $error("lower write upper half not from bus lanes");
endmodule
`default_nettype wire

// ===== design/vsr_router.sv
// Bus slave top: strobe handshake, board select, link use and upper memory.
// Assumes bus pins are synchronous to core_clk_in; pad buffers resolve the enables.
`timescale 1ns/1ns
`default_nettype none
module vsr_router
	import vsr_pkg::*;
#(
	parameter int UP_AW = 8,
	parameter int LO_AW = 8
) (
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire logic [31:1] bus_addr_in,
	input wire logic [5:0] bus_am_in,
	input wire logic bus_lword_n_in,
	input wire logic bus_as_n_in,
	input wire logic bus_ds0_n_in,
	input wire logic bus_ds1_n_in,
	input wire logic bus_write_n_in,
	input wire logic [31:0] bus_data_in,
	output logic [31:0] bus_data_out,
	output logic bus_data_hi_oe_out,
	output logic bus_data_lo_oe_out,
	output logic bus_dtack_n_out,
	output logic bus_dtack_oe_out,
	input wire logic [3:0] board_sw_in,
	input wire logic olk_req_in,
	output logic olk_gnt_out,
	input wire logic up_en_in,
	input wire logic up_we_in,
	input wire logic [UP_AW-1:0] up_addr_in,
	input wire logic [31:0] up_wdata_in,
	output logic [31:0] up_rdata_out,
	input wire logic lp_en_in,
	input wire logic lp_we_in,
	input wire logic [19:0] lp_addr_in,
	input wire logic [31:0] lp_wdata_in,
	output logic lp_gnt_out,
	output logic [31:0] lp_rdata_out
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		vsr_state_e st;
		logic as_q;
		logic [27:0] addr;
		logic wr;
		logic lw;
		logic lo;
		logic [15:0] wdat;
		logic [31:0] rd;
		logic drv;
		logic [5:0] hold;
		logic [31:0] up_rd;
	} vsr_top_s;
	vsr_top_s r_q;
	vsr_top_s r_d;
	logic [31:0] up_mem [2**UP_AW];
	vsr_link_if lk();
	logic am_ok;
	logic ext;
	logic match;
	logic as_fall;
	logic ds_low;
	logic ds_up;
	logic [27:0] offset;
	logic lo_hit;
	logic hold_done;
	logic [UP_AW-1:0] up_idx;
	logic [31:0] up_bus_rd;
	logic [15:0] upper_lane_rd;
	logic up_wr_bus;
	logic [31:0] up_wr_exp;
	logic [31:0] up_keep_exp;

	// ****************************************
	// Decode
	// ****************************************
	vsr_am_decode vsr_am_decode_inst (
		.am_in(bus_am_in),
		.addr_ext_in(bus_addr_in[31:28]),
		.addr_std_in(bus_addr_in[23:20]),
		.board_sw_in(board_sw_in),
		.am_ok_out(am_ok),
		.ext_out(ext),
		.match_out(match)
	);

	assign as_fall = r_q.as_q && !bus_as_n_in;
	assign ds_low = !bus_ds0_n_in || !bus_ds1_n_in;
	assign ds_up = bus_ds0_n_in && bus_ds1_n_in;
	assign offset = ext ? {bus_addr_in[27:1], 1'b0} : {8'h00, bus_addr_in[19:1], 1'b0};
	assign lo_hit = (offset >= LO_BASE) && (offset <= LO_LAST);
	assign hold_done = r_q.hold == 6'(LINK_HOLD_CYC - 1);
	assign up_idx = r_q.addr[UP_AW+1:2];
	assign up_bus_rd = up_mem[up_idx];

	// ****************************************
	// Link drive
	// ****************************************
	assign lk.req = r_q.st == ST_XFER;
	assign lk.wr = r_q.wr;
	assign lk.lo = r_q.lo;
	assign lk.we_hi = r_q.lw;
	assign lk.addr = {!(r_q.lo && !r_q.wr), r_q.addr[18:0]};
	assign lk.to_lo = {up_bus_rd[31:16], r_q.wdat};
	// The other link user loses its grant while the bus exchanges and when the hold-off limit runs out.
	assign olk_gnt_out = olk_req_in && (r_q.st != ST_XFER) && !((r_q.st == ST_WAIT) && hold_done);

	vsr_lower_route #(
		.LO_AW(LO_AW)
	) vsr_lower_route_inst (
		.clk_in(core_clk_in),
		.rst_in(sys_rst_in),
		.lk(lk),
		.bus_upper_lane_in(bus_data_in[31:16]),
		.bus_upper_lane_out(upper_lane_rd),
		.lp_en_in(lp_en_in),
		.lp_we_in(lp_we_in),
		.lp_addr_in(lp_addr_in),
		.lp_wdata_in(lp_wdata_in),
		.lp_gnt_out(lp_gnt_out),
		.lp_rdata_out(lp_rdata_out)
	);

	// ****************************************
	// Upper memory, two ports
	// ****************************************
	assign up_wr_bus = lk.req && r_q.wr && !r_q.lo;
	always_ff @(posedge core_clk_in) begin
		if (up_wr_bus) begin
			if (r_q.lw) begin
				up_mem[up_idx][31:16] <= lk.to_up[31:16];
			end
			up_mem[up_idx][15:0] <= r_q.wdat;
		end
		if (up_en_in && up_we_in && !(up_wr_bus && up_addr_in == up_idx)) begin
			up_mem[up_addr_in] <= up_wdata_in;
		end
	end

	// ****************************************
	// Transfer sequence
	// ****************************************
	always_comb begin
		r_d = r_q;
		r_d.as_q = bus_as_n_in;
		if (up_en_in) begin
			r_d.up_rd = up_mem[up_addr_in];
		end
		case (r_q.st)
			ST_IDLE: begin
				if (as_fall) begin
					r_d.st = (am_ok && match) ? ST_SEL : ST_END;
				end
			end
			ST_SEL: begin
				if (bus_as_n_in) begin
					r_d.st = ST_IDLE;
				end else if (ds_low) begin
					r_d.addr = offset;
					r_d.lo = lo_hit;
					r_d.wr = !bus_write_n_in;
					r_d.lw = !bus_lword_n_in;
					r_d.wdat = bus_data_in[15:0];
					r_d.hold = '0;
					r_d.st = ST_WAIT;
				end
			end
			ST_WAIT: begin
				r_d.hold = r_q.hold + 6'd1;
				if (!olk_req_in || hold_done) begin
					r_d.st = ST_XFER;
				end
			end
			ST_XFER: begin
				r_d.rd = {upper_lane_rd, r_q.lo ? lk.to_up[15:0] : up_bus_rd[15:0]};
				r_d.drv = !r_q.wr;
				r_d.st = ST_ACK;
			end
			ST_ACK: begin
				if (ds_up) begin
					r_d.drv = 1'b0;
					r_d.st = ST_END;
				end
			end
			ST_END: begin
				if (bus_as_n_in) begin
					r_d.st = ST_IDLE;
				end
			end
			default: r_d.st = ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			r_q <= '{st: ST_IDLE, as_q: 1'b1, default: '0};
		end else begin
			r_q <= r_d;
		end
	end

	// ****************************************
	// Pins
	// ****************************************
	assign bus_dtack_oe_out = (r_q.st == ST_ACK) && !ds_up;
	assign bus_dtack_n_out = 1'b0;
	assign bus_data_out = r_q.rd;
	assign bus_data_hi_oe_out = r_q.drv && r_q.lw && !ds_up;
	assign bus_data_lo_oe_out = r_q.drv && !ds_up;
	assign up_rdata_out = r_q.up_rd;

	// ****************************************
	// Checks
	// ****************************************
	// Expected upper words take their upper half from the bus pins or the stored word, not from the link path that writes them.
	assign up_wr_exp = {bus_data_in[31:16], r_q.wdat};
	assign up_keep_exp = {up_bus_rd[31:16], r_q.wdat};

	property p_bad_am;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		r_q.st == ST_IDLE && as_fall && !am_ok |=> (!bus_dtack_oe_out && !bus_data_lo_oe_out) [*4];
	endproperty
	a_bad_am: assert property (p_bad_am) else $error("unsupported modifier answered");

	property p_no_match;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		r_q.st == ST_IDLE && as_fall && am_ok && !match |=> r_q.st == ST_END;
	endproperty
	a_no_match: assert property (p_no_match) else $error("board mismatch not ignored");

	property p_std_compare;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		r_q.st == ST_IDLE && as_fall && am_ok && !ext && bus_addr_in[23:20] == board_sw_in |=> r_q.st == ST_SEL;
	endproperty
	a_std_compare: assert property (p_std_compare) else $error("standard board compare wrong");

	property p_latch;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		r_q.st == ST_SEL && !bus_as_n_in && ds_low |=> r_q.addr == $past(offset) && r_q.st == ST_WAIT;
	endproperty
	a_latch: assert property (p_latch) else $error("address not latched at data strobe");

	property p_flag;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		lk.req |-> lk.addr[ROUTE_BIT] == !(r_q.lo && !r_q.wr);
	endproperty
	a_flag: assert property (p_flag) else $error("route flag wrong on link");

	property p_xfer_ack;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		$rose(r_q.st == ST_XFER) |-> lk.req ##1 (r_q.st == ST_ACK) && (bus_dtack_oe_out || ds_up);
	endproperty
	a_xfer_ack: assert property (p_xfer_ack) else $error("acknowledge not after link exchange");

	property p_hold;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		$rose(r_q.st == ST_WAIT) |-> ##[1:40] r_q.st == ST_XFER;
	endproperty
	a_hold: assert property (p_hold) else $error("link hold-off too long");

	property p_release;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		r_q.st == ST_ACK && ds_up |-> !bus_dtack_oe_out ##1 (r_q.st == ST_END && !bus_data_lo_oe_out);
	endproperty
	a_release: assert property (p_release) else $error("acknowledge held after strobes rose");

	property p_up_write;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		up_wr_bus && r_q.lw |=> up_mem[$past(up_idx)] == $past(up_wr_exp);
	endproperty
	a_up_write: assert property (p_up_write) else $error("upper memory write data wrong");

	property p_up_keep;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		up_wr_bus && !r_q.lw |=> up_mem[$past(up_idx)] == $past(up_keep_exp);
	endproperty
	a_up_keep: assert property (p_up_keep) else $error("short write disturbed the upper half");

	property p_gnt_xfer;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		r_q.st == ST_XFER |-> !olk_gnt_out && lk.req;
	endproperty
	a_gnt_xfer: assert property (p_gnt_xfer) else $error("link granted to two users at once");

	property p_half_read;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		r_q.st == ST_ACK && !r_q.lw |-> !bus_data_hi_oe_out;
	endproperty
	a_half_read: assert property (p_half_read) else $error("upper lanes driven on a short cycle");

	property p_ack_drive;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		r_q.st == ST_ACK && !r_q.wr && !ds_up |-> bus_data_lo_oe_out && bus_dtack_oe_out;
	endproperty
	a_ack_drive: assert property (p_ack_drive) else $error("read acknowledged without data driven");

	property p_end_quiet;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		r_q.st == ST_END |-> !bus_dtack_oe_out && !bus_data_lo_oe_out && !bus_data_hi_oe_out;
	endproperty
	a_end_quiet: assert property (p_end_quiet) else $error("bus driven after the cycle ended");
endmodule
`default_nettype wire

// ===== verification/vsr_master_model.sv
// Bus master model: one single transfer per call, strobes released after acknowledge.
// Assumes the slave answers on the core clock and only one process calls xfer.
`timescale 1ns/1ns
`default_nettype none
module vsr_master_model (
	input wire logic clk_in,
	input wire logic dtack_oe_in,
	input wire logic hi_oe_in,
	input wire logic lo_oe_in,
	input wire logic [31:0] data_in,
	output logic [31:1] addr_out,
	output logic [5:0] am_out,
	output logic lword_n_out,
	output logic as_n_out,
	output logic ds0_n_out,
	output logic ds1_n_out,
	output logic write_n_out,
	output logic [31:0] data_out
);
	initial begin
		addr_out = '0;
		am_out = 6'h00;
		lword_n_out = 1'b1;
		as_n_out = 1'b1;
		ds0_n_out = 1'b1;
		ds1_n_out = 1'b1;
		write_n_out = 1'b1;
		data_out = 32'h5A5A_A5A5;
	end
	// ****************************************
	// Single transfer; released data and address lines show the inverse of their last value.
	// ****************************************
	task automatic xfer(input logic [31:0] a, input logic [5:0] am, input logic lw_n, input logic wr_n,
		input logic [31:0] wd, output logic [31:0] rd, output logic ack, output logic [1:0] oe,
		output int n, output logic rel);
		ack = 1'b0;
		oe = 2'h0;
		n = 0;
		@(posedge clk_in);
		#1;
		addr_out = a[31:1];
		am_out = am;
		lword_n_out = lw_n;
		write_n_out = wr_n;
		data_out = wr_n ? ~data_out : wd;
		@(posedge clk_in);
		#1;
		as_n_out = 1'b0;
		@(posedge clk_in);
		#1;
		ds0_n_out = 1'b0;
		ds1_n_out = 1'b0;
		while (!ack && n < 60) begin
			@(posedge clk_in);
			#1;
			n++;
			oe = oe | {hi_oe_in, lo_oe_in};
			ack = (dtack_oe_in === 1'b1);
		end
		// The answer is taken at the next edge, where acknowledge and data still stand.
		@(posedge clk_in);
		#1;
		oe = oe | {hi_oe_in, lo_oe_in};
		rd = data_in;
		ds0_n_out = 1'b1;
		ds1_n_out = 1'b1;
		data_out = ~data_out;
		#1;
		rel = (dtack_oe_in === 1'b0);
		@(posedge clk_in);
		#1;
		as_n_out = 1'b1;
		addr_out = ~addr_out;
		write_n_out = 1'b1;
		repeat (2) @(posedge clk_in);
		#1;
	endtask
endmodule
`default_nettype wire

// ===== verification/vsr_router_test.sv
// Self-checking bench for the bus slave top with a behavioural bus master.
// Assumes the design's internal assertions watch the protocol; this bench checks data.
`timescale 1ns/1ns
`default_nettype none
module vsr_router_test;
	import vsr_pkg::*;
	logic core_clk_in, sys_rst_in, lword_n, as_n, ds0_n, ds1_n, write_n, hi_oe, lo_oe, dtack_n, dtack_oe;
	logic [31:1] addr;
	logic [5:0] am;
	logic [31:0] bus_wd, bus_rd, bus_seen, up_wdata, up_rdata, lp_wdata, lp_rdata, rd;
	logic [3:0] board_sw;
	logic olk_req, olk_gnt, up_en, up_we, lp_en, lp_we, lp_gnt, ack, rel;
	logic [7:0] up_addr;
	logic [19:0] lp_addr;
	logic [1:0] oe;
	int n;
	int err_total = 0;
	int n_compared = 0;
	localparam logic [31:0] SA = 32'h00A0_0010;
	localparam logic [31:0] EA = 32'hA000_0010;
	localparam logic [31:0] LA = 32'h00A2_0010;
	logic [5:0] codes [12] = '{6'h0F, 6'h0E, 6'h0D, 6'h0B, 6'h0A, 6'h09, 6'h3F, 6'h3E, 6'h3D, 6'h3B, 6'h3A, 6'h39};

	vsr_router vsr_router_inst (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .bus_addr_in(addr),
		.bus_am_in(am), .bus_lword_n_in(lword_n), .bus_as_n_in(as_n), .bus_ds0_n_in(ds0_n), .bus_ds1_n_in(ds1_n),
		.bus_write_n_in(write_n), .bus_data_in(bus_wd), .bus_data_out(bus_rd), .bus_data_hi_oe_out(hi_oe),
		.bus_data_lo_oe_out(lo_oe), .bus_dtack_n_out(dtack_n), .bus_dtack_oe_out(dtack_oe),
		.board_sw_in(board_sw), .olk_req_in(olk_req), .olk_gnt_out(olk_gnt), .up_en_in(up_en), .up_we_in(up_we),
		.up_addr_in(up_addr), .up_wdata_in(up_wdata), .up_rdata_out(up_rdata), .lp_en_in(lp_en),
		.lp_we_in(lp_we), .lp_addr_in(lp_addr), .lp_wdata_in(lp_wdata), .lp_gnt_out(lp_gnt),
		.lp_rdata_out(lp_rdata));
	// Undriven lanes show the inverse of the register, so data is only right while it is driven.
	assign bus_seen = {hi_oe ? bus_rd[31:16] : ~bus_rd[31:16], lo_oe ? bus_rd[15:0] : ~bus_rd[15:0]};
	vsr_master_model vsr_master_model_inst (.clk_in(core_clk_in), .dtack_oe_in(dtack_oe), .hi_oe_in(hi_oe),
		.lo_oe_in(lo_oe), .data_in(bus_seen), .addr_out(addr), .am_out(am), .lword_n_out(lword_n),
		.as_n_out(as_n), .ds0_n_out(ds0_n), .ds1_n_out(ds1_n), .write_n_out(write_n), .data_out(bus_wd));

	// ****************************************
	// Compare, transfer and closing tasks.
	// ****************************************
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_flag(input logic got, input logic exp);
		chk_word({31'h0000_0000, got}, {31'h0000_0000, exp});
	endtask
	task automatic bus(input logic [31:0] a, input logic [5:0] c, input logic lw, input logic wr,
		input logic [31:0] wd);
		vsr_master_model_inst.xfer(a, c, lw, wr, wd, rd, ack, oe, n, rel);
	endtask
	task automatic wr32(input logic [31:0] a, input logic [5:0] c, input logic [31:0] d);
		bus(a, c, 1'b0, 1'b0, d);
		chk_flag(ack, 1'b1);
		chk_flag(rel, 1'b1);
	endtask
	task automatic rd32(input logic [31:0] a, input logic [5:0] c, input logic [31:0] exp);
		bus(a, c, 1'b0, 1'b1, 32'h0000_0000);
		chk_flag(ack, 1'b1);
		chk_word(rd, exp);
		chk_word({30'h0000_0000, oe}, 32'h0000_0003);
	endtask
	task automatic summarize;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ****************************************
	// Scenarios.
	// ****************************************
	task automatic t_codes;
		for (int i = 0; i < 12; i++) begin
			wr32((i < 6 ? EA : SA) + 32'(4 * i), codes[i], 32'h1000_0000 + 32'(i));
			rd32((i < 6 ? EA : SA) + 32'(4 * i), codes[i], 32'h1000_0000 + 32'(i));
			chk_word(32'(n), 32'h0000_0003);
		end
		$display("done t_codes");
	endtask
	task automatic t_refused;
		wr32(SA, 6'h39, 32'h1234_5678);
		bus(SA, 6'h29, 1'b0, 1'b0, 32'hDEAD_0001);
		chk_flag(ack | oe[0] | oe[1], 1'b0);
		bus(32'h0050_0010, 6'h39, 1'b0, 1'b0, 32'hDEAD_0002);
		chk_flag(ack | oe[0] | oe[1], 1'b0);
		bus(SA, 6'h09, 1'b0, 1'b0, 32'hDEAD_0003);
		chk_flag(ack, 1'b0);
		rd32(32'h70A0_0010, 6'h39, 32'h1234_5678);
		$display("done t_refused");
	endtask
	task automatic t_lower;
		wr32(LA, 6'h39, 32'hCAFE_F00D);
		rd32(LA, 6'h39, 32'hCAFE_F00D);
		wr32(32'hA002_0020, 6'h0D, 32'h8765_4321);
		rd32(32'hA002_0020, 6'h0D, 32'h8765_4321);
		@(posedge core_clk_in);
		#1;
		chk_flag(lp_gnt, 1'b1);
		lp_en = 1'b1;
		lp_addr = 20'h2_0010;
		@(posedge core_clk_in);
		#1;
		lp_en = 1'b0;
		chk_word(lp_rdata, 32'hCAFE_F00D);
		lp_en = 1'b1;
		lp_we = 1'b1;
		lp_addr = 20'h2_0030;
		lp_wdata = 32'h0BAD_BEEF;
		@(posedge core_clk_in);
		#1;
		lp_en = 1'b0;
		lp_we = 1'b0;
		rd32(LA + 32'h0000_0020, 6'h3D, 32'h0BAD_BEEF);
		$display("done t_lower");
	endtask
	task automatic t_half;
		wr32(SA + 32'h0000_0040, 6'h39, 32'h1111_2222);
		bus(SA + 32'h0000_0040, 6'h39, 1'b1, 1'b0, 32'h0000_AAAA);
		chk_flag(ack, 1'b1);
		rd32(SA + 32'h0000_0040, 6'h39, 32'h1111_AAAA);
		bus(SA + 32'h0000_0040, 6'h39, 1'b1, 1'b1, 32'h0000_0000);
		chk_word({16'h0000, rd[15:0]}, 32'h0000_AAAA);
		chk_word({30'h0000_0000, oe}, 32'h0000_0001);
		$display("done t_half");
	endtask
	task automatic t_holdoff;
		@(posedge core_clk_in);
		#1;
		olk_req = 1'b1;
		#1;
		chk_flag(olk_gnt, 1'b1);
		rd32(SA + 32'h0000_0040, 6'h39, 32'h1111_AAAA);
		chk_flag(n > 3 && n <= 43, 1'b1);
		olk_req = 1'b0;
		$display("done t_holdoff");
	endtask
	task automatic t_ports;
		@(posedge core_clk_in);
		#1;
		up_en = 1'b1;
		up_we = 1'b1;
		up_addr = 8'h20;
		up_wdata = 32'h5555_AAAA;
		@(posedge core_clk_in);
		#1;
		up_we = 1'b0;
		up_addr = 8'h04;
		@(posedge core_clk_in);
		#1;
		up_en = 1'b0;
		chk_word(up_rdata, 32'h1234_5678);
		rd32(32'h00A0_0080, 6'h39, 32'h5555_AAAA);
		$display("done t_ports");
	endtask

	initial begin
		core_clk_in = 1'b0;
		forever #25 core_clk_in = ~core_clk_in;
	end
	initial begin
		#(5000 * 50);
		err_total++;
		summarize();
	end
	initial begin
		sys_rst_in = 1'b1;
		board_sw = 4'hA;
		{olk_req, up_en, up_we, lp_en, lp_we} = 5'h00;
		up_addr = 8'h00;
		up_wdata = 32'h0000_0000;
		lp_addr = 20'h0_0000;
		lp_wdata = 32'h0000_0000;
		repeat (3) @(posedge core_clk_in);
		#1;
		chk_flag(dtack_oe | hi_oe | lo_oe, 1'b0);
		chk_flag(dtack_n, 1'b0);
		sys_rst_in = 1'b0;
		t_codes();
		t_refused();
		t_lower();
		t_half();
		t_holdoff();
		t_ports();
		summarize();
	end
endmodule
`default_nettype wire
